// [hw/adc_ctrl_pkg.sv]
// Shared constants, types and register map for the converter control block
package adc_ctrl_pkg;

  // Result word
  localparam int          RESULT_BITS        = 20;
  localparam int          MAX_WORD_BITS      = 32;

  // APB register byte offsets
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_STATUS         = 8'h04;
  localparam logic [7:0]  REG_IRQ_STATUS     = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK       = 8'h0c;
  localparam logic [7:0]  REG_RESULT         = 8'h10;
  localparam logic [7:0]  REG_CAL_ZERO       = 8'h14;
  localparam logic [7:0]  REG_CAL_FULL       = 8'h18;
  localparam logic [7:0]  REG_CAL_SPAN       = 8'h1c;

  // Control register fields
  localparam int          CTRL_BIPOLAR       = 0;
  localparam logic        CTRL_RESET         = 1'h0;

  // Status register fields
  localparam int          ST_SELF_MODE       = 0;
  localparam int          ST_CAL_BUSY        = 1;
  localparam int          ST_SEL_A           = 2;
  localparam int          ST_SEL_B           = 3;
  localparam int          ST_VALID           = 4;
  localparam int          ST_SHIFTING        = 5;

  // Interrupt status / mask fields
  localparam int          IRQ_BITS           = 4;
  localparam int          IRQ_WORD_DONE      = 0;
  localparam int          IRQ_NEW_WORD       = 1;
  localparam int          IRQ_CAL_DONE       = 2;
  localparam int          IRQ_CAL_RESET      = 3;
  localparam logic [3:0]  IRQ_MASK_RESET     = 4'h0;

  // Timing counts in master clock cycles
  localparam logic [2:0]  CAL_RESET_CYCLES   = 3'h4;
  localparam logic [2:0]  LOAD_BUSY_CYCLES   = 3'h4;
  localparam int          SCLK_DIV           = 4;
  localparam int          SCLK_CNT_W         = 2;

  // Pin inputs that cross into the master clock domain
  typedef struct packed {
    logic mode_self;
    logic cal_strobe;
    logic sel_a;
    logic sel_b;
    logic cs_n;
    logic sclk;
  } pins_t;

  localparam pins_t       PINS_RESET         = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  // Calibration types and sequencer states
  typedef struct packed {
    logic sel_a;
    logic sel_b;
  } cal_sel_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b000,
    CAL_ZERO = 3'b001,
    CAL_FULL = 3'b010,
    CAL_SELF = 3'b011
  } cal_state_t;

endpackage

// [hw/adc_serial_ctrl.sv]
// Serial output, calibration control and APB registers of the converter
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Strap low selects external clock mode; shift clock pin is an input.
// - External clock mode shifts the raw result word, MSB first, no framing.
// - Strap high selects self clock mode; shift clock out at master/4, 25% high.
// - Select levels captured on calibration strobe rise choose the calibration.
// - Select B low runs system calibration, offset taken from the analog input.
// - System calibration takes zero then full scale level; span comes from both.
// - Unipolar codes are straight binary, all zeros to all ones.
// - Bipolar codes are offset binary, midscale between 0111.. and 1000...
// - Strobe high over four cycles resets; calibration starts when it falls.
// - Chip select low starts transmission in the strap-selected format.
// - Each conversion leaves as one 20-bit serial word.
// - Valid flag low while data held, high once the word has gone out.
module adc_serial_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int WORD_W = adc_ctrl_pkg::RESULT_BITS
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Pins
  input  wire logic              mode_strap,
  input  wire logic              cal_strobe,
  input  wire logic              trim_type_select_a,
  input  wire logic              trim_type_select_b,
  input  wire logic              cs_n,
  input  wire logic              sclk_in,
  output wire logic              sclk_out,
  output var  logic              sclk_oe,
  output wire logic              serial_result_out,
  output wire logic              serial_result_oe,
  output var  logic              result_valid_n,
  output var  logic              irq,
  // Filter side, same clock
  input  wire logic [WORD_W-1:0] sample_in,
  input  wire logic              sample_valid
);

  // Word width must fit a register and the shifter
  if (WORD_W < 2 || WORD_W > MAX_WORD_BITS) begin : g_bad_width
    $error("WORD_W out of range");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers; third stage only for the shift clock and calibration strobe edge detectors
  pins_t pins_raw;
  pins_t pins_s1;
  pins_t pins_s2;
  logic  sclk_s3;
  logic  strobe_d;

  assign pins_raw = '{mode_strap, cal_strobe, trim_type_select_a,
                      trim_type_select_b, cs_n, sclk_in};

  // Two flops before any logic reads a pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pins_s1  <= PINS_RESET;
      pins_s2  <= PINS_RESET;
      sclk_s3  <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      pins_s1  <= pins_raw;
      pins_s2  <= pins_s1;
      sclk_s3  <= pins_s2.sclk;
      strobe_d <= pins_s2.cal_strobe;
    end
  end

  wire self_mode   = pins_s2.mode_self;
  wire strobe_rise = pins_s2.cal_strobe && !strobe_d;
  wire strobe_fall = !pins_s2.cal_strobe && strobe_d;
  wire ext_fall    = sclk_s3 && !pins_s2.sclk;      // Data moves on host falling edge
  wire selected    = !pins_s2.cs_n;

  // ---------------------------------------------------------------------------
  // Calibration strobe: select capture and long-high reset
  cal_sel_t   cal_sel;
  logic [2:0] strobe_cnt;
  logic       strobe_long;

  wire long_hit = pins_s2.cal_strobe && (strobe_cnt == CAL_RESET_CYCLES) && !strobe_long;

  // Count saturates one past the limit so the reset fires only once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cal_sel     <= '{1'b0, 1'b0};
      strobe_cnt  <= '0;
      strobe_long <= 1'b0;
    end else begin
      if (strobe_rise) begin
        cal_sel <= '{pins_s2.sel_a, pins_s2.sel_b};
      end
      if (!pins_s2.cal_strobe) begin
        strobe_cnt  <= '0;
        strobe_long <= 1'b0;
      end else if (!strobe_long) begin
        strobe_cnt <= strobe_cnt + 1'b1;
        if (long_hit) begin
          strobe_long <= 1'b1;
        end
      end
    end
  end

  // A strobe held past four cycles clears the output path
  wire cal_reset = long_hit;

  // ---------------------------------------------------------------------------
  // Calibration sequencer
  cal_state_t        cal_state;
  logic [WORD_W-1:0] cal_zero;
  logic [WORD_W-1:0] cal_full;
  logic              cal_done;

  wire cal_busy = (cal_state != CAL_IDLE);

  // System type waits for one sample per level; the system must settle the
  // input between the two steps, as no sample is discarded
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cal_state <= CAL_IDLE;
      cal_zero  <= '0;
      cal_full  <= '0;
      cal_done  <= 1'b0;
    end else begin
      cal_done <= 1'b0;
      if (strobe_rise) begin
        cal_state <= CAL_IDLE;
      end else begin
        case (cal_state)
          CAL_IDLE: begin
            if (strobe_fall) begin
              cal_state <= cal_sel.sel_b ? CAL_SELF : CAL_ZERO;
            end
          end
          CAL_ZERO: begin
            if (sample_valid) begin
              cal_zero  <= sample_in;
              cal_state <= CAL_FULL;
            end
          end
          CAL_FULL: begin
            if (sample_valid) begin
              cal_full  <= sample_in;
              cal_state <= CAL_IDLE;
              cal_done  <= 1'b1;
            end
          end
          CAL_SELF: begin
            cal_zero  <= '0;
            cal_full  <= '1;
            cal_state <= CAL_IDLE;
            cal_done  <= 1'b1;
          end
          default: begin
            cal_state <= CAL_IDLE;
          end
        endcase
      end
    end
  end

  // Span only; gain correction is left to software reading it
  wire [WORD_W-1:0] cal_span = cal_full - cal_zero;

  // ---------------------------------------------------------------------------
  // Output coding and output register
  logic              bipolar;
  logic [WORD_W-1:0] out_word;
  logic [2:0]        load_cnt;

  wire [WORD_W-1:0] corrected = sample_in - cal_zero;
  // Bipolar: two's complement to offset binary by flipping the MSB
  wire [WORD_W-1:0] coded     = bipolar ? {~corrected[WORD_W-1], corrected[WORD_W-2:0]}
                                        : corrected;
  wire              new_word  = sample_valid && !cal_busy;

  wire shift_busy;
  wire shift_done;
  wire self_tick;
  wire start_tx  = selected && !result_valid_n && !shift_busy && !cal_busy;

  // Loading a word holds the valid flag high for four cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_word       <= '0;
      load_cnt       <= '0;
      result_valid_n <= 1'b1;
    end else if (cal_reset) begin
      load_cnt       <= '0;
      result_valid_n <= 1'b1;
    end else if (new_word) begin
      out_word       <= coded;
      load_cnt       <= LOAD_BUSY_CYCLES;
      result_valid_n <= 1'b1;
    end else if (load_cnt != '0) begin
      load_cnt <= load_cnt - 1'b1;
      if (load_cnt == 3'h1) begin
        result_valid_n <= 1'b0;
      end
    end else if (shift_done) begin
      result_valid_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial engines; the strap picks the shift source
  wire shift_pulse = self_mode ? self_tick : ext_fall;

  sclk_divider u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .en      (self_mode && shift_busy),
    .sclk    (sclk_out),
    .tick    (self_tick)
  );

  word_shifter #(
    .W (WORD_W)
  ) u_shift (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (start_tx),
    .word    (out_word),
    .shift   (shift_pulse),
    .abort   (!selected),
    .flush   (cal_reset),
    .bit_out (serial_result_out),
    .oe      (serial_result_oe),
    .busy    (shift_busy),
    .done    (shift_done)
  );

  // Shift clock pin driven only in self clock mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= self_mode;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status, mask and output
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] irq_event;

  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_WORD_DONE] = shift_done;
    irq_event[IRQ_NEW_WORD]  = new_word;
    irq_event[IRQ_CAL_DONE]  = cal_done;
    irq_event[IRQ_CAL_RESET] = cal_reset;
  end

  // ---------------------------------------------------------------------------
  // APB slave: no wait state, registered answer
  wire apb_setup  = psel && !penable;
  wire apb_done   = psel && penable && pready;
  wire apb_write  = apb_done && pwrite && !pslverr;
  wire irq_rd_clr = apb_done && !pwrite && (paddr == REG_IRQ_STATUS);

  wire hit = (paddr == REG_CTRL)     || (paddr == REG_STATUS)   ||
             (paddr == REG_IRQ_STATUS) || (paddr == REG_IRQ_MASK) ||
             (paddr == REG_RESULT)   || (paddr == REG_CAL_ZERO) ||
             (paddr == REG_CAL_FULL) || (paddr == REG_CAL_SPAN);

  wire [31:0] status_word = 32'({shift_busy, !result_valid_n, cal_sel.sel_b,
                                 cal_sel.sel_a, cal_busy, self_mode});

  // Read data selection
  wire [31:0] rd_data =
    (paddr == REG_CTRL)       ? 32'(bipolar)    :
    (paddr == REG_STATUS)     ? status_word     :
    (paddr == REG_IRQ_STATUS) ? 32'(irq_status) :
    (paddr == REG_IRQ_MASK)   ? 32'(irq_mask)   :
    (paddr == REG_RESULT)     ? 32'(out_word)   :
    (paddr == REG_CAL_ZERO)   ? 32'(cal_zero)   :
    (paddr == REG_CAL_FULL)   ? 32'(cal_full)   :
    (paddr == REG_CAL_SPAN)   ? 32'(cal_span)   : 32'h0000_0000;

  // Answer prepared in the setup cycle, ready in the first access cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !hit;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bipolar  <= CTRL_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (apb_write) begin
      if (paddr == REG_CTRL) begin
        bipolar <= pwdata[CTRL_BIPOLAR];
      end
      if (paddr == REG_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_BITS-1:0];
      end
    end
  end

  // Sticky events; a read clears only the bits it returned, so an event after setup is kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_rd_clr ? irq_status & ~prdata[IRQ_BITS-1:0] : irq_status) | irq_event;
      irq <= |(((irq_rd_clr ? irq_status & ~prdata[IRQ_BITS-1:0] : irq_status) | irq_event) & irq_mask);
    end
  end

endmodule
`default_nettype wire

// [hw/sclk_divider.sv]
// Divide-by-four shift clock generator with a fall tick
`timescale 1ns/1ns
`default_nettype none
module sclk_divider
  import adc_ctrl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic en,
  output var  logic sclk,
  output var  logic tick
);

  logic [SCLK_CNT_W-1:0] cnt;
  wire                   phase_zero = en && (cnt == '0);

  // Modulo-four count, high one count in four; restarts with each word
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= '0;
      sclk <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt  <= en ? cnt + 1'b1 : '0;
      sclk <= phase_zero;
      tick <= sclk && en;           // Marks the falling edge cycle
    end
  end

endmodule
`default_nettype wire

// [hw/word_shifter.sv]
// MSB-first shifter for one result word
`timescale 1ns/1ns
`default_nettype none
module word_shifter #(
  parameter int W = 20
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] word,
  input  wire logic         shift,
  input  wire logic         abort,
  input  wire logic         flush,
  output wire logic         bit_out,
  output var  logic         oe,
  output var  logic         busy,
  output var  logic         done
);

  localparam int IW = (W > 1) ? $clog2(W) : 1;

  logic [W-1:0]  sh;
  logic [IW-1:0] idx;

  assign bit_out = sh[W-1];

  // Raw word, no framing bits; a deselect finishes the current bit first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh   <= '0;
      idx  <= '0;
      oe   <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (flush) begin
      oe   <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        sh   <= word;
        idx  <= IW'(W - 1);
        oe   <= 1'b1;
        busy <= 1'b1;
      end else if (busy && shift) begin
        if (idx == '0) begin
          oe   <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
        end else if (abort) begin
          oe   <= 1'b0;
          busy <= 1'b0;
        end else begin
          sh  <= {sh[W-2:0], 1'b0};
          idx <= idx - 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [verification/adc_serial_ctrl_checker.sv]
// Pin-level assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_serial_ctrl_checker #(
  parameter int WORD_W = 20
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic mode_strap,
  input wire logic cs_n,
  input wire logic sclk_in,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic result_valid_n
);
  logic [5:0] pulses;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Shift clock pulses of the word in flight
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulses <= 6'h0;
    end else if (!serial_result_oe) begin
      pulses <= 6'h0;
    end else if (sclk_out) begin
      pulses <= pulses + 6'h1;
    end
  end

  a_strap_self: assert property (mode_strap [*5] |-> sclk_oe)
    else $error("shift clock pin not driven in self clock mode");
  a_strap_ext: assert property (!mode_strap [*5] |-> !sclk_oe)
    else $error("shift clock pin driven in external clock mode");
  a_sclk_quiet: assert property ((!sclk_oe || !serial_result_oe) |-> !sclk_out)
    else $error("shift clock pulse outside a self clocked word");
  a_sclk_duty: assert property (sclk_out |=> !sclk_out [*3])
    else $error("shift clock high longer than one cycle in four");
  a_sclk_period: assert property (sclk_out ##4 serial_result_oe |-> sclk_out)
    else $error("shift clock period not four cycles");
  a_word_len: assert property ($fell(serial_result_oe) && sclk_oe && !cs_n |-> pulses == 6'(WORD_W))
    else $error("word length differs from the result width");
  a_self_shift: assert property (sclk_oe && serial_result_oe && $past(serial_result_oe)
    && $changed(serial_result_out) |-> $past(sclk_out, 2))
    else $error("data bit moved without a shift clock pulse");
  a_ext_shift: assert property (!sclk_oe && serial_result_oe && $past(serial_result_oe)
    && $changed(serial_result_out) |-> !sclk_in)
    else $error("data bit moved while host clock high");
  a_start_cause: assert property ($rose(serial_result_oe) |-> $past(!result_valid_n) && !$past(cs_n, 2))
    else $error("word started without chip select and valid data");
  a_load_gap: assert property ($fell(result_valid_n) |-> $past(result_valid_n, 2) && $past(result_valid_n, 4))
    else $error("valid flag fell without the load gap");

  c_self_word: cover property ($fell(serial_result_oe) && sclk_oe);
  c_ext_word: cover property ($fell(serial_result_oe) && !sclk_oe);
  c_load: cover property ($fell(result_valid_n));
endmodule

bind adc_serial_ctrl adc_serial_ctrl_checker #(.WORD_W(WORD_W)) chk_i (
  .sys_clk           (sys_clk),
  .rstn              (rstn),
  .mode_strap        (mode_strap),
  .cs_n              (cs_n),
  .sclk_in           (sclk_in),
  .sclk_out          (sclk_out),
  .sclk_oe           (sclk_oe),
  .serial_result_out (serial_result_out),
  .serial_result_oe  (serial_result_oe),
  .result_valid_n    (result_valid_n)
);
`default_nettype wire

// [verification/adc_serial_ctrl_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_serial_ctrl_tb;
  import adc_ctrl_pkg::*;
  logic        sys_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mode_strap;
  logic        cal_strobe;
  logic        sel_a;
  logic        sel_b;
  logic        cs_n;
  logic        host_sclk;
  logic        sclk_out;
  logic        sclk_oe;
  logic        sd_out;
  logic        sd_oe;
  logic        last_sd;
  logic        result_valid_n;
  logic        irq;
  logic [19:0] sample_in;
  logic        sample_valid;
  logic [19:0] w;
  logic        ok;
  int          n_errors;
  int          compares;
  // Pin levels; a released data line shows the inverse of its last bit
  wire logic   sclk_pin = sclk_oe ? sclk_out : host_sclk;
  wire logic   sd_pin = sd_oe ? sd_out : ~last_sd;

  adc_serial_ctrl #(.WORD_W(20)) adc_serial_ctrl_i (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_strap(mode_strap), .cal_strobe(cal_strobe), .trim_type_select_a(sel_a),
    .trim_type_select_b(sel_b), .cs_n(cs_n), .sclk_in(sclk_pin), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .serial_result_out(sd_out), .serial_result_oe(sd_oe),
    .result_valid_n(result_valid_n), .irq(irq), .sample_in(sample_in), .sample_valid(sample_valid));

  host_serial_model #(.W(20)) host_serial_model_i (
    .sys_clk(sys_clk), .self_mode(mode_strap), .sd_pin(sd_pin), .sclk_pin(sclk_pin),
    .cs_n(cs_n), .sclk_drv(host_sclk));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (sd_oe === 1'b1) last_sd <= sd_out;
  end

  task automatic end_sim;
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ends on a falling edge so that flop outputs are settled
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic load(input logic [19:0] v);
    @(posedge sys_clk);
    sample_in <= v;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    idle(8);
  endtask

  task automatic strobe(input int n);
    @(posedge sys_clk);
    cal_strobe <= 1'b1;
    repeat (n) @(posedge sys_clk);
    cal_strobe <= 1'b0;
    idle(12);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd(REG_CTRL, 32'h0000_0000);
    rd(REG_IRQ_MASK, 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_000f);
    rd(REG_IRQ_MASK, 32'h0000_000f);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(32'(e), 32'h0000_0001);
    wr(REG_IRQ_MASK, 32'h0000_0000);
  endtask

  // Select levels changed as the strobe falls still give the captured pair
  task automatic t_self_cal;
    @(posedge sys_clk);
    sel_a <= 1'b1;
    sel_b <= 1'b1;
    @(posedge sys_clk);
    cal_strobe <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cal_strobe <= 1'b0;
    sel_a <= 1'b0;
    idle(12);
    rd(REG_STATUS, 32'h0000_000c);
  endtask

  task automatic t_sys_cal;
    @(posedge sys_clk);
    sel_b <= 1'b0;
    strobe(3);
    load(20'h0_0100);
    load(20'h8_0100);
    rd(REG_CAL_ZERO, 32'h0000_0100);
    rd(REG_CAL_FULL, 32'h0008_0100);
    rd(REG_CAL_SPAN, 32'h0008_0000);
  endtask

  task automatic t_ext_uni;
    rd(REG_IRQ_STATUS, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    load(20'h0_0100);
    rd(REG_RESULT, 32'h0000_0000);
    load(20'h0_0123);
    chk(32'(result_valid_n), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    host_serial_model_i.frame(w, ok);
    idle(2);
    chk(32'(ok), 32'h0000_0001);
    chk(32'(w), 32'h0000_0023);
    chk(32'(result_valid_n), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    rd(REG_IRQ_STATUS, 32'h0000_0003);
    idle(3);
    chk(32'(irq), 32'h0000_0000);
  endtask

  task automatic t_self_bip;
    @(posedge sys_clk);
    mode_strap <= 1'b1;
    idle(5);
    wr(REG_CTRL, 32'h0000_0001);
    load(20'h0_0100);
    host_serial_model_i.frame(w, ok);
    chk(32'(w), 32'h0008_0000);
    load(20'h0_00ff);
    host_serial_model_i.frame(w, ok);
    chk(32'(w), 32'h0007_ffff);
  endtask

  // Strobe held past four cycles resets, then calibrates on release
  task automatic t_long;
    rd(REG_IRQ_STATUS, 32'h0000_0003);
    wr(REG_IRQ_MASK, 32'h0000_0008);
    sel_b <= 1'b1;
    load(20'h0_0200);
    @(posedge sys_clk);
    cal_strobe <= 1'b1;
    idle(10);
    chk(32'(result_valid_n), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    @(posedge sys_clk);
    cal_strobe <= 1'b0;
    idle(12);
    rd(REG_IRQ_STATUS, 32'h0000_000e);
  endtask

  // Deselect mid-word: bit in flight ends, word stays valid and goes out whole later
  task automatic t_cut;
    load(20'h0_0155);
    host_serial_model_i.cut(30);
    rd(REG_STATUS, 32'h0000_0039);
    idle(8);
    chk(32'(sd_oe), 32'h0000_0000);
    chk(32'(result_valid_n), 32'h0000_0000);
    host_serial_model_i.frame(w, ok);
    chk(32'(w), 32'h0008_0155);
  endtask

  initial begin
    n_errors = 0;
    compares = 0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_strap, cal_strobe, sel_a, sel_b, sample_valid} = '0;
    sample_in = '0;
    last_sd = 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_self_cal();
    t_sys_cal();
    t_ext_uni();
    t_self_bip();
    t_long();
    t_cut();
    end_sim();
  end
endmodule
`default_nettype wire

// [verification/host_serial_model.sv]
// Host shift register that clocks result words out of the converter
`timescale 1ns/1ns
`default_nettype none
module host_serial_model #(
  parameter int W = 20
) (
  input  wire logic sys_clk,
  input  wire logic self_mode,
  input  wire logic sd_pin,
  input  wire logic sclk_pin,
  output var  logic cs_n,
  output var  logic sclk_drv
);
  initial begin
    cs_n = 1'b1;
    sclk_drv = 1'b0;
  end

  // One whole frame; host clock stands low outside it
  task automatic frame(output logic [W-1:0] w, output logic ok);
    int n;
    int k;
    n = 0;
    w = '0;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    if (self_mode) begin
      // Device clocks; bit taken mid high cycle
      for (k = 0; k < 400 && n < W; k++) begin
        @(negedge sys_clk);
        if (sclk_pin === 1'b1) begin
          w = {w[W-2:0], sd_pin};
          n++;
        end
      end
    end else begin
      // 160 ns clock, phase unrelated to the master clock
      #303;
      for (n = 0; n < W; n++) begin
        sclk_drv = 1'b1;
        w = {w[W-2:0], sd_pin};
        #80 sclk_drv = 1'b0;
        #80;
      end
    end
    repeat (12) @(posedge sys_clk);
    cs_n <= 1'b1;
    ok = (n == W);
  endtask

  // Frame cut short after n master clock cycles; no host clock given
  task automatic cut(input int n);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire
